// ===== core/clockgen_pkg.sv
package clockgen_pkg;

	// ========================================================
	// Register map, one aligned 32-bit word each.
	localparam logic [7:0] PLL_CONTROL_OFS = 8'h00;
	localparam logic [7:0] PLL_BANDWIDTH_OFS = 8'h04;
	localparam logic [7:0] BREAK_FLAG_CTRL_OFS = 8'h08;
	localparam logic [7:0] EVENT_STATUS_OFS = 8'h0c;
	localparam logic [7:0] EVENT_MASK_OFS = 8'h10;

	// ========================================================
	// Field positions.
	localparam int IRQ_ENABLE_BIT = 7;
	localparam int IRQ_FLAG_BIT = 6;
	localparam int POWER_ON_BIT = 5;
	localparam int BASE_SEL_BIT = 4;
	localparam int AUTO_BIT = 7;
	localparam int LOCK_BIT = 6;
	localparam int TRACKING_BIT = 5;
	localparam int BREAK_CLEAR_BIT = 7;
	localparam int EV_LOCK_CHANGE = 0;
	localparam int EV_ACQ_DONE = 1;
	localparam int EV_STOP_WAKE = 2;
	localparam int EV_WIDTH = 3;

	// ========================================================
	// Values after reset and read-as-one bits.
	localparam logic [3:0] CONTROL_LOW_ONES = 4'hf;
	localparam logic RESET_POWER_ON = 1'b1;
	localparam logic [EV_WIDTH-1:0] RESET_EV_MASK = 3'h0;

	// ========================================================
	// Counts of cycles.
	localparam int QUAL_WIDTH = 8;
	localparam logic [QUAL_WIDTH-1:0] ACQ_WINDOW_REFS = 8'h20;
	localparam logic [QUAL_WIDTH-1:0] TRK_WINDOW_REFS = 8'h40;
	localparam logic [3:0] REF_DIV_XTAL = 4'h4;

	// Control bits of the PLL control register.
	typedef struct packed {
		logic irq_enable;
		logic power_on;
		logic base_sel;
	} pll_ctl_s;

	// Bandwidth control bits.
	typedef struct packed {
		logic auto_mode;
		logic tracking_manual;
	} bw_ctl_s;

endpackage

// ===== core/lock_qualifier.sv
`timescale 1ns/100ps

// Counts a window of reference ticks and declares qualified only if the
// tolerance input held for the whole window.
module lock_qualifier (
	input wire logic clock_in, // System clock.
	input wire logic rstn_in, // Asynchronous reset, active low.
	input wire logic enable_in, // Qualification allowed.
	input wire logic ref_tick_in, // One-cycle reference tick.
	input wire logic in_tol_in, // Error within tolerance.
	input wire logic [clockgen_pkg::QUAL_WIDTH-1:0] window_in, // Ticks.
	output logic qualified_out // Window passed, held while in tolerance.
);

	logic [clockgen_pkg::QUAL_WIDTH-1:0] count_q;
	logic clean_q;

	// =======================================================
	// Window counter, cleared whenever qualification is off.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_q <= '0;
			clean_q <= 1'b1;
			qualified_out <= 1'b0;
		end else if (!enable_in) begin
			count_q <= '0;
			clean_q <= 1'b1;
			qualified_out <= 1'b0;
		end else if (qualified_out) begin
			// Leaving tolerance drops qualification at once.
			if (!in_tol_in) begin
				qualified_out <= 1'b0;
			end
		end else if (ref_tick_in) begin
			if (count_q == window_in - 1'b1) begin
				// Whole window judged; a failed window restarts.
				qualified_out <= clean_q & in_tol_in;
				count_q <= '0;
				clean_q <= 1'b1;
			end else begin
				count_q <= count_q + 1'b1;
				clean_q <= clean_q & in_tol_in;
			end
		end
	end

endmodule

// ===== core/pll_clock_stop_break_lock_logic.sv
`timescale 1ns/100ps

module pll_clock_stop_break_lock_logic (
	input wire logic clock_in, // 40 MHz system clock.
	input wire logic rstn_in, // Asynchronous reset, active low.
	input wire logic psel_in, // APB select.
	input wire logic penable_in, // APB enable.
	input wire logic pwrite_in, // APB direction.
	input wire logic [7:0] paddr_in, // APB byte address.
	input wire logic [31:0] pwdata_in, // APB write data.
	output logic [31:0] prdata_out, // APB read data.
	output logic pready_out, // APB ready.
	output logic pslverr_out, // APB error, unmapped address.
	input wire logic stop_in, // Stop instruction executes, pulse.
	input wire logic wake_in, // Recovery from stop, pulse.
	input wire logic break_in, // Break state, level.
	input wire logic vco_clock_in, // VCO clock, asynchronous.
	input wire logic trk_tol_in, // Error within tracking tolerance.
	input wire logic lock_tol_in, // Error within lock tolerance.
	output logic crystal_ref_clock_out, // Crystal clock output.
	output logic base_clock_out, // Base clock output.
	output logic clockgen_irq_out, // Interrupt line, level.
	output logic pll_power_on_out // PLL enable to the analog loop.
);

	clockgen_pkg::pll_ctl_s ctl_q;
	clockgen_pkg::bw_ctl_s bw_q;
	logic pll_irq_flag_q;
	logic break_clear_enable_q;
	logic [clockgen_pkg::EV_WIDTH-1:0] ev_status_q;
	logic [clockgen_pkg::EV_WIDTH-1:0] ev_mask_q;
	logic stopped_q;
	logic [2:0] vco_sync_q;
	logic [1:0] trk_sync_q;
	logic [1:0] lock_sync_q;
	logic [3:0] ref_div_q;
	logic ref_tick_q;
	logic acq_done;
	logic lock_done;
	logic lock_prev_q;
	logic acq_prev_q;
	logic xtal_rise;
	logic vco_rise;
	logic qual_en;
	logic bus_write;
	logic bus_read;
	logic sel_ctl;
	logic sel_bw;
	logic sel_brk;
	logic sel_sts;
	logic sel_msk;
	logic mapped;
	logic protect;
	logic lock_view;
	logic lock_change;
	logic [31:0] rd_d;

	// =======================================================
	// Address decode and access strobes; writes act at the access edge.
	assign sel_ctl = paddr_in == clockgen_pkg::PLL_CONTROL_OFS;
	assign sel_bw = paddr_in == clockgen_pkg::PLL_BANDWIDTH_OFS;
	assign sel_brk = paddr_in == clockgen_pkg::BREAK_FLAG_CTRL_OFS;
	assign sel_sts = paddr_in == clockgen_pkg::EVENT_STATUS_OFS;
	assign sel_msk = paddr_in == clockgen_pkg::EVENT_MASK_OFS;
	assign mapped = sel_ctl | sel_bw | sel_brk | sel_sts | sel_msk;
	assign bus_write = psel_in & penable_in & pready_out & pwrite_in;
	assign bus_read = psel_in & penable_in & pready_out & ~pwrite_in;
	// Break state without clear enable shields flags from software.
	assign protect = break_in & ~break_clear_enable_q;

	// =======================================================
	// Two-flop synchronisers for the asynchronous inputs.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vco_sync_q <= 3'h0;
			trk_sync_q <= 2'h0;
			lock_sync_q <= 2'h0;
		end else begin
			vco_sync_q <= {vco_sync_q[1:0], vco_clock_in};
			trk_sync_q <= {trk_sync_q[0], trk_tol_in};
			lock_sync_q <= {lock_sync_q[0], lock_tol_in};
		end
	end

	// Rising edge of the synchronised VCO clock, read from later stages.
	assign vco_rise = vco_sync_q[1] & ~vco_sync_q[2];
	// The crystal output toggles every cycle, so it rises every other one.
	assign xtal_rise = ~crystal_ref_clock_out & ~stopped_q;

	// =======================================================
	// Crystal clock output and reference divider; all halt in stop.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			crystal_ref_clock_out <= 1'b0;
			ref_div_q <= 4'h0;
			ref_tick_q <= 1'b0;
		end else if (stopped_q | stop_in) begin
			crystal_ref_clock_out <= 1'b0;
			ref_div_q <= 4'h0;
			ref_tick_q <= 1'b0;
		end else begin
			crystal_ref_clock_out <= ~crystal_ref_clock_out;
			ref_tick_q <= 1'b0;
			if (xtal_rise) begin
				if (ref_div_q == clockgen_pkg::REF_DIV_XTAL - 4'h1) begin
					ref_div_q <= 4'h0;
					ref_tick_q <= 1'b1;
				end else begin
					ref_div_q <= ref_div_q + 4'h1;
				end
			end
		end
	end

	// =======================================================
	// Base clock toggles on each rising edge of the chosen source: half rate.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			base_clock_out <= 1'b0;
		end else if (stopped_q | stop_in) begin
			base_clock_out <= 1'b0;
		end else if (ctl_q.base_sel ? vco_rise : xtal_rise) begin
			base_clock_out <= ~base_clock_out;
		end
	end

	// =======================================================
	// Stop state, entered by the stop pulse and left by the wake pulse.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stopped_q <= 1'b0;
		end else if (stop_in) begin
			stopped_q <= 1'b1;
		end else if (wake_in) begin
			stopped_q <= 1'b0;
		end
	end

	// =======================================================
	// PLL control bits with their mutual protection.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctl_q <= '{irq_enable: 1'b0,
				power_on: clockgen_pkg::RESET_POWER_ON, base_sel: 1'b0};
		end else if (stop_in) begin
			ctl_q.base_sel <= 1'b0;
		end else if (bus_write & sel_ctl) begin
			ctl_q.irq_enable <= pwdata_in[clockgen_pkg::IRQ_ENABLE_BIT];
			// Power may not drop while the VCO drives the base clock,
			// nor in the write that hands the base clock to the VCO.
			ctl_q.power_on <= pwdata_in[clockgen_pkg::POWER_ON_BIT] |
				ctl_q.base_sel |
				(pwdata_in[clockgen_pkg::BASE_SEL_BIT] &
				ctl_q.power_on);
			// The VCO may be chosen only while the PLL is already on.
			ctl_q.base_sel <= pwdata_in[clockgen_pkg::BASE_SEL_BIT] &
				ctl_q.power_on;
		end
	end

	// =======================================================
	// Bandwidth mode and manual tracking bit; the latter is kept
	// while automatic mode owns the status.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bw_q <= '0;
		end else if (bus_write & sel_bw) begin
			bw_q.auto_mode <= pwdata_in[clockgen_pkg::AUTO_BIT];
			if (!bw_q.auto_mode) begin
				bw_q.tracking_manual <=
					pwdata_in[clockgen_pkg::TRACKING_BIT];
			end
		end
	end

	// Break flag control, cleared by reset to protect the flag.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			break_clear_enable_q <= 1'b0;
		end else if (bus_write & sel_brk) begin
			break_clear_enable_q <= pwdata_in[clockgen_pkg::BREAK_CLEAR_BIT];
		end
	end

	// =======================================================
	// Lock qualification over counted reference windows.
	assign qual_en = bw_q.auto_mode & ctl_q.power_on & ~stopped_q &
		~stop_in;

	lock_qualifier acq_qual (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.enable_in(qual_en),
		.ref_tick_in(ref_tick_q),
		.in_tol_in(trk_sync_q[1]),
		.window_in(clockgen_pkg::ACQ_WINDOW_REFS),
		.qualified_out(acq_done)
	);

	lock_qualifier lock_qual (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.enable_in(qual_en & acq_done),
		.ref_tick_in(ref_tick_q),
		.in_tol_in(lock_sync_q[1]),
		.window_in(clockgen_pkg::TRK_WINDOW_REFS),
		.qualified_out(lock_done)
	);

	assign lock_view = bw_q.auto_mode & lock_done;
	assign lock_change = lock_view != lock_prev_q;

	// =======================================================
	// PLL flag: lock changes set it, control reads clear it; set wins.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lock_prev_q <= 1'b0;
			acq_prev_q <= 1'b0;
			pll_irq_flag_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_view;
			acq_prev_q <= acq_done;
			if (!bw_q.auto_mode) begin
				pll_irq_flag_q <= 1'b0;
			end else if (lock_change) begin
				pll_irq_flag_q <= 1'b1;
			end else if (bus_read & sel_ctl & ~protect) begin
				pll_irq_flag_q <= 1'b0;
			end
		end
	end

	// =======================================================
	// Sticky event status, write one to clear, with its mask.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ev_status_q <= '0;
			ev_mask_q <= clockgen_pkg::RESET_EV_MASK;
		end else begin
			if (bus_write & sel_msk) begin
				ev_mask_q <= pwdata_in[clockgen_pkg::EV_WIDTH-1:0];
			end
			for (int i = 0; i < clockgen_pkg::EV_WIDTH; i++) begin
				if ((i == clockgen_pkg::EV_LOCK_CHANGE && lock_change) ||
					(i == clockgen_pkg::EV_ACQ_DONE &&
					acq_done && !acq_prev_q) ||
					(i == clockgen_pkg::EV_STOP_WAKE &&
					wake_in && stopped_q)) begin
					ev_status_q[i] <= 1'b1;
				end else if (bus_write && sel_sts && pwdata_in[i] &&
					!protect) begin
					ev_status_q[i] <= 1'b0;
				end
			end
		end
	end

	// =======================================================
	// Interrupt line and PLL enable, registered; quiet during stop.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clockgen_irq_out <= 1'b0;
			pll_power_on_out <= 1'b0;
		end else begin
			clockgen_irq_out <= ~stopped_q & ~stop_in &
				((pll_irq_flag_q & ctl_q.irq_enable) |
				(|(ev_status_q & ev_mask_q)));
			pll_power_on_out <= ctl_q.power_on & ~stopped_q & ~stop_in;
		end
	end

	// =======================================================
	// Read multiplexer.
	always_comb begin
		rd_d = 32'h0;
		if (sel_ctl) begin
			rd_d[clockgen_pkg::IRQ_ENABLE_BIT] = ctl_q.irq_enable;
			rd_d[clockgen_pkg::IRQ_FLAG_BIT] = pll_irq_flag_q;
			rd_d[clockgen_pkg::POWER_ON_BIT] = ctl_q.power_on;
			rd_d[clockgen_pkg::BASE_SEL_BIT] = ctl_q.base_sel;
			rd_d[3:0] = clockgen_pkg::CONTROL_LOW_ONES;
		end else if (sel_bw) begin
			rd_d[clockgen_pkg::AUTO_BIT] = bw_q.auto_mode;
			rd_d[clockgen_pkg::LOCK_BIT] = lock_view;
			rd_d[clockgen_pkg::TRACKING_BIT] = bw_q.auto_mode ?
				acq_done : bw_q.tracking_manual;
		end else if (sel_brk) begin
			rd_d[clockgen_pkg::BREAK_CLEAR_BIT] = break_clear_enable_q;
		end else if (sel_sts) begin
			rd_d[clockgen_pkg::EV_WIDTH-1:0] = ev_status_q;
		end else if (sel_msk) begin
			rd_d[clockgen_pkg::EV_WIDTH-1:0] = ev_mask_q;
		end
	end

	// =======================================================
	// APB answer: ready in the first access cycle, data from setup.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0;
		end else if (psel_in & ~penable_in) begin
			pready_out <= 1'b1;
			pslverr_out <= ~mapped;
			prdata_out <= pwrite_in ? 32'h0 : rd_d;
		end else begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

endmodule

// ===== verification/clockgen_sva.sv
`timescale 1ns/100ps

// ========================================
// Port checker for the clock generator.
module clockgen_sva (
	input wire logic clock_in, // Clock.
	input wire logic rstn_in, // Reset, active low.
	input wire logic psel_in, // Select.
	input wire logic penable_in, // Enable.
	input wire logic pwrite_in, // Direction.
	input wire logic [7:0] paddr_in, // Address.
	input wire logic [31:0] pwdata_in, // Write data.
	input wire logic [31:0] prdata_out, // Read data.
	input wire logic pready_out, // Ready.
	input wire logic pslverr_out, // Error.
	input wire logic stop_in, // Stop pulse.
	input wire logic wake_in, // Wake pulse.
	input wire logic crystal_ref_clock_out, // Crystal clock.
	input wire logic base_clock_out, // Base clock.
	input wire logic clockgen_irq_out, // Interrupt.
	input wire logic pll_power_on_out // PLL enable.
);
	logic stopped_q;
	logic xtal_src_q;

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	// Tracks whether the generator has been stopped.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stopped_q <= 1'b0;
		end else if (stop_in) begin
			stopped_q <= 1'b1;
		end else if (wake_in) begin
			stopped_q <= 1'b0;
		end
	end

	// Tracks whether the crystal is known to source the base clock.
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			xtal_src_q <= 1'b1;
		end else if (wake_in) begin
			xtal_src_q <= 1'b1;
		end else if (psel_in && !penable_in && pwrite_in && paddr_in == 8'h00
			&& pwdata_in[clockgen_pkg::BASE_SEL_BIT]) begin
			xtal_src_q <= 1'b0;
		end
	end

	stop_low_a: assert property (stopped_q |-> !crystal_ref_clock_out
		&& !base_clock_out && !clockgen_irq_out && !pll_power_on_out)
		else $error("output not low in stop");
	xtal_pulse_a: assert property ($rose(crystal_ref_clock_out)
		|=> $fell(crystal_ref_clock_out))
		else $error("crystal clock high too long");
	xtal_run_a: assert property ($fell(crystal_ref_clock_out) && !stop_in
		&& !stopped_q |=> crystal_ref_clock_out)
		else $error("crystal clock stalled");
	base_half_a: assert property (xtal_src_q && !stop_in
		&& $rose(base_clock_out) |=> base_clock_out ##1 !base_clock_out)
		else $error("base clock not crystal halved");
	apb_ready_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("ready missing in access cycle");
	ready_phase_a: assert property (pready_out |-> psel_in && penable_in)
		else $error("ready outside access cycle");
	err_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	err_data_a: assert property (pready_out && pslverr_out && !pwrite_in
		|-> prdata_out == 32'h0)
		else $error("refused read not zero");
endmodule

bind pll_clock_stop_break_lock_logic clockgen_sva i_chk (.clock_in, .rstn_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
	.pready_out, .pslverr_out, .stop_in, .wake_in, .crystal_ref_clock_out,
	.base_clock_out, .clockgen_irq_out, .pll_power_on_out);

// ===== verification/pll_loop_model.sv
`timescale 1ns/100ps

// ========================================
// Analog loop stand-in: VCO clock and tolerance levels.
module pll_loop_model (
	input wire logic pll_power_on_in, // PLL enable from the block.
	input wire logic trk_ok_in, // Error may reach the tracking band.
	input wire logic lock_ok_in, // Error may reach the lock band.
	output logic vco_clock_out, // VCO clock, still while off.
	output logic trk_tol_out, // Error within tracking tolerance.
	output logic lock_tol_out // Error within lock tolerance.
);
	// The VCO runs only while powered, below a quarter of the system clock.
	initial vco_clock_out = 1'b0;
	always #65 vco_clock_out = pll_power_on_in ? ~vco_clock_out : 1'b0;

	// A loop that is off is never in tolerance; lock lies inside tracking.
	assign trk_tol_out = pll_power_on_in & trk_ok_in;
	assign lock_tol_out = trk_tol_out & lock_ok_in;
endmodule

// ===== verification/tb.sv
`timescale 1ns/100ps

// ========================================
// Self-checking bench for the clock generator.
module tb;
	logic clock_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0;
	logic pwrite_in = 0, stop_in = 0, wake_in = 0, break_in = 0;
	logic trk_ok = 0, lock_ok = 0, err;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic pready_out, pslverr_out, vco, trk_tol, lock_tol, xtal, base, irq, pwr;
	int failures = 0;
	int num_checks = 0;
	int n;

	// Clock at 40 MHz.
	always #12.5 clock_in = ~clock_in;

	pll_clock_stop_break_lock_logic i_dut (.clock_in, .rstn_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
		.pready_out, .pslverr_out, .stop_in, .wake_in, .break_in,
		.vco_clock_in(vco), .trk_tol_in(trk_tol), .lock_tol_in(lock_tol),
		.crystal_ref_clock_out(xtal), .base_clock_out(base),
		.clockgen_irq_out(irq), .pll_power_on_out(pwr));
	pll_loop_model i_loop (.pll_power_on_in(pwr), .trk_ok_in(trk_ok),
		.lock_ok_in(lock_ok), .vco_clock_out(vco), .trk_tol_out(trk_tol),
		.lock_tol_out(lock_tol));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock_in);
	endtask

	// One APB transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clock_in);
			k++;
		end while (pready_out !== 1'b1 && k < 20);
		if (k == 20) begin
			failures++;
			print_verdict;
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clock_in);
	endtask

	task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask

	// Polls the bandwidth register until lock shows, within a bound.
	task automatic wait_lock;
		n = 0;
		do begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end while (rd[6] !== 1'b1 && n < 500);
		if (n == 500) begin
			failures++;
			print_verdict;
		end
	endtask

	task automatic t_reset;
		rd_chk("control", 8'h00, 32'h2f);
		rd_chk("bandwidth", 8'h04, 32'h0);
		rd_chk("break ctrl", 8'h08, 32'h0);
		rd_chk("status", 8'h0c, 32'h0);
		rd_chk("mask", 8'h10, 32'h0);
		rd_chk("unmapped data", 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, 8'h04, 32'h20);
		rd_chk("manual tracking", 8'h04, 32'h20);
		$display("reset test done");
	endtask

	task automatic t_acq;
		apb(1'b1, 8'h04, 32'h80);
		trk_ok <= 1'b1;
		cyc(150);
		trk_ok <= 1'b0;
		cyc(20);
		trk_ok <= 1'b1;
		lock_ok <= 1'b1;
		cyc(230);
		rd_chk("tracking early", 8'h04, 32'h80);
		wait_lock;
		chk("lock time", 32'h1, {31'h0, n * 3 >= 520});
		chk("bandwidth locked", 32'he0, rd);
		rd_chk("events", 8'h0c, 32'h3);
		rd_chk("flag set", 8'h00, 32'h6f);
		rd_chk("flag cleared", 8'h00, 32'h2f);
		$display("lock test done");
	endtask

	task automatic t_irq;
		apb(1'b1, 8'h10, 32'h1);
		cyc(2);
		chk("irq masked on", 32'h1, {31'h0, irq});
		apb(1'b1, 8'h0c, 32'h1);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd_chk("status w1c", 8'h0c, 32'h2);
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h00, 32'ha0);
		lock_ok <= 1'b0;
		cyc(10);
		chk("irq lock loss", 32'h1, {31'h0, irq});
		rd_chk("flag on loss", 8'h00, 32'hef);
		cyc(2);
		chk("irq after read", 32'h0, {31'h0, irq});
		$display("interrupt test done");
	endtask

	task automatic t_break;
		lock_ok <= 1'b1;
		wait_lock;
		cyc(4);
		break_in <= 1'b1;
		rd_chk("break read", 8'h00, 32'hef);
		apb(1'b1, 8'h00, 32'ha0);
		rd_chk("break write", 8'h00, 32'hef);
		apb(1'b1, 8'h08, 32'h80);
		rd_chk("break clear", 8'h00, 32'hef);
		rd_chk("cleared in break", 8'h00, 32'haf);
		break_in <= 1'b0;
		cyc(2);
		rd_chk("stays clear", 8'h00, 32'haf);
		apb(1'b1, 8'h08, 32'h0);
		$display("break test done");
	endtask

	task automatic t_stop;
		apb(1'b1, 8'h00, 32'h10);
		rd_chk("power kept", 8'h00, 32'h3f);
		cyc(20);
		stop_in <= 1'b1;
		cyc(1);
		stop_in <= 1'b0;
		cyc(5);
		chk("outputs stopped", 32'h0, {28'h0, xtal, base, irq, pwr});
		wake_in <= 1'b1;
		cyc(1);
		wake_in <= 1'b0;
		cyc(4);
		apb(1'b0, 8'h00, 32'h0);
		chk("select cleared", 32'h0, {31'h0, rd[4]});
		apb(1'b0, 8'h04, 32'h0);
		chk("tracking restart", 32'h0, {31'h0, rd[5]});
		apb(1'b0, 8'h0c, 32'h0);
		chk("wake event", 32'h1, {31'h0, rd[2]});
		$display("stop test done");
	endtask

	// Main sequence: reset for ten cycles, then each scenario.
	initial begin
		cyc(10);
		rstn_in <= 1'b1;
		cyc(1);
		t_reset;
		t_acq;
		t_irq;
		t_break;
		t_stop;
		print_verdict;
	end
endmodule
